//--- pkg/gpio_group_pkg.sv
// constants, register map and carrier types of the gpio port group
package gpio_group_pkg;
  localparam int PINS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_IO_GATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_PULL_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EDGE_EVENT_FLAGS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EDGE_EVENT_ENABLES = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DEBOUNCE_ENABLES = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PERIPHERAL_SELECT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_KEY_RESET_SELECT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_GROUP_SUMMARY = 8'h20;
  // field positions of the two register halves
  localparam int HI_LSB = 8;
  localparam int HI_MSB = 15;
  localparam int LO_LSB = 0;
  localparam int LO_MSB = 7;
  localparam int KRS_W = 2;
  // reset values
  localparam logic [PINS-1:0] RST_BYTE = 8'h00;
  localparam logic [KRS_W-1:0] RST_KRS = 2'h0;
  // key reset selection codes
  localparam logic [KRS_W-1:0] KRS_OFF = 2'h0;
  localparam logic [KRS_W-1:0] KRS_PINS_1_0 = 2'h1;
  localparam logic [KRS_W-1:0] KRS_PINS_2_0 = 2'h2;
  localparam logic [KRS_W-1:0] KRS_PINS_3_0 = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // system clocks per debounce clock period
  localparam int DEB_DIV_DEFAULT = 16;
  localparam int DEB_CNT_W = 16;

  typedef struct packed {
    logic [PINS-1:0] out;
    logic [PINS-1:0] oe;
    logic [PINS-1:0] pull_up;
    logic [PINS-1:0] pull_down;
  } pad_ctrl_t;

  typedef struct packed {
    logic [PINS-1:0] out;
    logic [PINS-1:0] oe;
  } periph_drive_t;
endpackage : gpio_group_pkg

//--- rtl/gpio_port_group_edge_irq.sv
// gpio port group with edge flags, key reset and axi4-lite slave
// What this block does
// RULE1: without debounce, request key reset at once when all selected pins low.
// RULE2: with debounce on those pins, request only after filtered low level.
// RULE3: key reset pins keep working as normal inputs with edge flags.
// RULE4: software makes key reset pins inputs before setting the selection.
// RULE5: edge interrupts work only for pins in general-purpose mode.
// RULE6: set fall or rise flag on each edge; cleared only by writing one.
// RULE7: group summary reads one while any enabled flag is set.
// RULE8: interrupt request only when a set flag has its enable set.
// RULE9: a set flag with its enable clear does not set the summary.
// RULE10: clearing the flags also clears the summary without another write.
// RULE11: drive gate on drives output value; otherwise writes are stored only.
// RULE12: input bit shows live level while input gate on, else zero.
// RULE13: in peripheral mode the input bit does not show the pin.
// RULE14: both gates on: input bit reads back the driven level.
// RULE15: input gates in bits 15:8, drive gates 7:0; drive off is high impedance.
// RULE16: pull direction one is up, zero is down; applied only with pull gate.
// RULE17: pulling only while drive gate is off, whatever the input gate.
// RULE18: all gpio gate and pull settings ignored in peripheral mode.
// RULE19: flags: fall in 15:8, rise in 7:0; write one clears, zero ignored.
// RULE20: enables: fall in 15:8, rise in 7:0; both give both edges.
// RULE21: software clears a flag before enabling its interrupt.
// RULE22: debounce enable bits 7:0 route pin through filter; 15:8 read zero.
// RULE23: debounce off bypasses the filter.
// RULE24: selection 0 off, 1 pins 1:0, 2 pins 2:0, 3 pins 3:0.
// RULE25: peripheral select one hands pin to peripheral, zero keeps gpio.
// RULE26: filter rejects pulses shorter than one to two debounce periods.
// RULE27: edges from gated input against previous sample.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_group_edge_irq #(
  parameter int DEB_DIV = gpio_group_pkg::DEB_DIV_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [gpio_group_pkg::ADDR_W-1:0] s_awaddr,
  // axi4-lite write data
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [gpio_group_pkg::DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // axi4-lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // axi4-lite read address
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [gpio_group_pkg::ADDR_W-1:0] s_araddr,
  // axi4-lite read data
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [gpio_group_pkg::DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  // pads
  input wire logic [gpio_group_pkg::PINS-1:0] pad_in,
  output gpio_group_pkg::pad_ctrl_t pad_ctrl,
  // peripheral function side
  input wire gpio_group_pkg::periph_drive_t periph_drive,
  output logic [gpio_group_pkg::PINS-1:0] periph_in,
  // events
  output logic irq,
  output logic key_reset_req
);
  import gpio_group_pkg::*;

  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // software registers
  logic [PINS-1:0] pin_output_value;
  logic [PINS-1:0] input_gate;
  logic [PINS-1:0] drive_gate;
  logic [PINS-1:0] pull_direction;
  logic [PINS-1:0] pull_gate;
  logic [PINS-1:0] fall_edge_flag;
  logic [PINS-1:0] rise_edge_flag;
  logic [PINS-1:0] fall_edge_irq_on;
  logic [PINS-1:0] rise_edge_irq_on;
  logic [PINS-1:0] debounce_on;
  logic [PINS-1:0] peripheral_select;
  logic [KRS_W-1:0] key_reset_select;
  logic group_irq_summary;
  logic [PINS-1:0] pin_input_value;

  // three-flop pad synchroniser
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] sync_c;
  logic [PINS-1:0] raw_level;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_a <= RST_BYTE;
      sync_b <= RST_BYTE;
      sync_c <= RST_BYTE;
    end else begin
      sync_a <= pad_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // level accepted once stages two and three agree
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      raw_level <= RST_BYTE;
    end else begin
      raw_level <= (sync_b & sync_c) | (raw_level & (sync_b | sync_c));
    end
  end

  // debounce clock enable from a divider
  logic [DEB_CNT_W-1:0] deb_cnt;
  logic deb_tick;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      deb_cnt <= '0;
      deb_tick <= 1'b0;
    end else if (deb_cnt == DEB_CNT_W'(DEB_DIV - 1)) begin
      deb_cnt <= '0;
      deb_tick <= 1'b1;
    end else begin
      deb_cnt <= deb_cnt + 1'b1;
      deb_tick <= 1'b0;
    end
  end

  // per-pin filter: a new level must be seen on two successive ticks
  logic [PINS-1:0] deb_sample;
  logic [PINS-1:0] deb_level;
  logic [PINS-1:0] filt_level;
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_deb
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          deb_sample[gi] <= 1'b0;
          deb_level[gi] <= 1'b0;
        end else if (deb_tick) begin
          deb_sample[gi] <= raw_level[gi];
          // RULE26 two-tick agreement
          if (deb_sample[gi] == raw_level[gi]) begin
            deb_level[gi] <= raw_level[gi];
          end
        end
      end
      // RULE22 RULE23 filter or bypass
      assign filt_level[gi] = debounce_on[gi] ? deb_level[gi] : raw_level[gi];
    end
  endgenerate

  // gated input for read-back and edges
  logic [PINS-1:0] next_input_value;
  always_comb begin
    // RULE14 loop back own drive when both gates on
    next_input_value = (drive_gate & pin_output_value) | (~drive_gate & filt_level);
    // RULE12 RULE13 gate and peripheral mask
    next_input_value = next_input_value & input_gate & ~peripheral_select;
  end

  logic [PINS-1:0] prev_input_value;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_input_value <= RST_BYTE;
      prev_input_value <= RST_BYTE;
    end else begin
      // RULE27 sample each clock
      pin_input_value <= next_input_value;
      prev_input_value <= pin_input_value;
    end
  end

  // RULE5 RULE27 edges only in gpio mode
  logic [PINS-1:0] rise_hit;
  logic [PINS-1:0] fall_hit;
  assign rise_hit = pin_input_value & ~prev_input_value & ~peripheral_select;
  assign fall_hit = ~pin_input_value & prev_input_value & ~peripheral_select;

  // axi4-lite slave
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic wr_hit;
  logic [1:0] wr_lane;
  logic [PINS-1:0] flag_clr_fall;
  logic [PINS-1:0] flag_clr_rise;
  assign wr_fire = aw_full && w_full && !s_bvalid;
  assign wr_lane = w_strb_q[1:0];

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_GROUP_SUMMARY);
  endfunction : mapped

  function automatic logic [PINS-1:0] lane_write(input logic [PINS-1:0] old,
                                                 input logic [PINS-1:0] val,
                                                 input logic en);
    lane_write = en ? val : old;
  endfunction : lane_write

  assign wr_hit = mapped(aw_addr_q);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_full <= 1'b0;
      s_awready <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_awvalid && s_awready) begin
      aw_full <= 1'b1;
      s_awready <= 1'b0;
      aw_addr_q <= s_awaddr;
    end else if (wr_fire || !aw_full) begin
      aw_full <= 1'b0;
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      w_full <= 1'b0;
      s_wready <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_full <= 1'b1;
      s_wready <= 1'b0;
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end else if (wr_fire || !w_full) begin
      w_full <= 1'b0;
      s_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // control register writes
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_output_value <= RST_BYTE;
      input_gate <= RST_BYTE;
      drive_gate <= RST_BYTE;
      pull_direction <= RST_BYTE;
      pull_gate <= RST_BYTE;
      fall_edge_irq_on <= RST_BYTE;
      rise_edge_irq_on <= RST_BYTE;
      debounce_on <= RST_BYTE;
      peripheral_select <= RST_BYTE;
      key_reset_select <= RST_KRS;
    end else if (wr_fire) begin
      unique case (aw_addr_q)
        // RULE11 value stored whatever the gates
        OFS_PIN_DATA: begin
          pin_output_value <= lane_write(pin_output_value, w_data_q[HI_MSB:HI_LSB], wr_lane[1]);
        end
        // RULE15 gate fields
        OFS_PIN_IO_GATE: begin
          input_gate <= lane_write(input_gate, w_data_q[HI_MSB:HI_LSB], wr_lane[1]);
          drive_gate <= lane_write(drive_gate, w_data_q[LO_MSB:LO_LSB], wr_lane[0]);
        end
        OFS_PIN_PULL_CONTROL: begin
          pull_direction <= lane_write(pull_direction, w_data_q[HI_MSB:HI_LSB], wr_lane[1]);
          pull_gate <= lane_write(pull_gate, w_data_q[LO_MSB:LO_LSB], wr_lane[0]);
        end
        // RULE20 enable fields
        OFS_EDGE_EVENT_ENABLES: begin
          fall_edge_irq_on <= lane_write(fall_edge_irq_on, w_data_q[HI_MSB:HI_LSB], wr_lane[1]);
          rise_edge_irq_on <= lane_write(rise_edge_irq_on, w_data_q[LO_MSB:LO_LSB], wr_lane[0]);
        end
        OFS_DEBOUNCE_ENABLES: begin
          debounce_on <= lane_write(debounce_on, w_data_q[LO_MSB:LO_LSB], wr_lane[0]);
        end
        // RULE25 peripheral hand-over
        OFS_PERIPHERAL_SELECT: begin
          peripheral_select <= lane_write(peripheral_select, w_data_q[LO_MSB:LO_LSB], wr_lane[0]);
        end
        OFS_KEY_RESET_SELECT: begin
          if (wr_lane[0]) begin
            key_reset_select <= w_data_q[KRS_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // RULE19 write one clears, zero ignored
  assign flag_clr_fall = (wr_fire && aw_addr_q == OFS_EDGE_EVENT_FLAGS && wr_lane[1]) ?
                         w_data_q[HI_MSB:HI_LSB] : RST_BYTE;
  assign flag_clr_rise = (wr_fire && aw_addr_q == OFS_EDGE_EVENT_FLAGS && wr_lane[0]) ?
                         w_data_q[LO_MSB:LO_LSB] : RST_BYTE;

  // an edge in the clearing cycle wins so no event is lost
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fall_edge_flag <= RST_BYTE;
      rise_edge_flag <= RST_BYTE;
    end else begin
      // RULE6 set on edge, clear by software
      fall_edge_flag <= (fall_edge_flag & ~flag_clr_fall) | fall_hit;
      rise_edge_flag <= (rise_edge_flag & ~flag_clr_rise) | rise_hit;
    end
  end

  // summary and irq lag the flags by one clock
  logic next_summary;
  assign next_summary = |((fall_edge_flag & fall_edge_irq_on) | (rise_edge_flag & rise_edge_irq_on));
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      group_irq_summary <= 1'b0;
      irq <= 1'b0;
    end else begin
      // RULE7 RULE9 RULE10 masked summary
      group_irq_summary <= next_summary;
      // RULE8 masked request
      irq <= next_summary;
    end
  end

  // key reset sees filtered levels whatever the gates and mode
  logic [3:0] key_mask;
  logic next_key_reset;
  always_comb begin
    key_mask = 4'h0;
    // RULE24 pin set selection
    unique case (key_reset_select)
      KRS_OFF: key_mask = 4'h0;
      KRS_PINS_1_0: key_mask = 4'h3;
      KRS_PINS_2_0: key_mask = 4'h7;
      KRS_PINS_3_0: key_mask = 4'hF;
    endcase
    // RULE1 RULE2 RULE3 all selected pins low
    next_key_reset = (key_mask != 4'h0) && ((filt_level[3:0] & key_mask) == 4'h0);
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      key_reset_req <= 1'b0;
    end else begin
      key_reset_req <= next_key_reset;
    end
  end

  // pad drive and pulls
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_ctrl <= '0;
      periph_in <= RST_BYTE;
    end else begin
      // RULE11 RULE18 mux between gpio and peripheral drive
      pad_ctrl.out <= (peripheral_select & periph_drive.out) | (~peripheral_select & pin_output_value);
      // RULE15 drive gate off leaves pin floating
      pad_ctrl.oe <= (peripheral_select & periph_drive.oe) | (~peripheral_select & drive_gate);
      // RULE16 RULE17 RULE18 pulls only with drive off in gpio mode
      pad_ctrl.pull_up <= ~peripheral_select & ~drive_gate & pull_gate & pull_direction;
      pad_ctrl.pull_down <= ~peripheral_select & ~drive_gate & pull_gate & ~pull_direction;
      periph_in <= raw_level & peripheral_select;
    end
  end

  // read channel: one cycle from address to data
  logic [DATA_W-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    unique case (s_araddr)
      OFS_PIN_DATA: rd_word[HI_MSB:0] = {pin_output_value, pin_input_value};
      OFS_PIN_IO_GATE: rd_word[HI_MSB:0] = {input_gate, drive_gate};
      OFS_PIN_PULL_CONTROL: rd_word[HI_MSB:0] = {pull_direction, pull_gate};
      OFS_EDGE_EVENT_FLAGS: rd_word[HI_MSB:0] = {fall_edge_flag, rise_edge_flag};
      OFS_EDGE_EVENT_ENABLES: rd_word[HI_MSB:0] = {fall_edge_irq_on, rise_edge_irq_on};
      // RULE22 upper half reads zero
      OFS_DEBOUNCE_ENABLES: rd_word[LO_MSB:0] = debounce_on;
      OFS_PERIPHERAL_SELECT: rd_word[LO_MSB:0] = peripheral_select;
      OFS_KEY_RESET_SELECT: rd_word[KRS_W-1:0] = key_reset_select;
      OFS_GROUP_SUMMARY: rd_word[0] = group_irq_summary;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end
endmodule : gpio_port_group_edge_irq
`default_nettype wire

//--- bench/gpio_port_group_edge_irq_properties.sv
// port-level checks for the gpio port group
`timescale 1ns/1ps
`default_nettype none
module gpio_group_checks #(
  parameter int DEB_DIV = gpio_group_pkg::DEB_DIV_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [gpio_group_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic [1:0] s_bresp,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [gpio_group_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_rvalid,
  input wire logic [gpio_group_pkg::DATA_W-1:0] s_rdata,
  input wire logic [1:0] s_rresp,
  // pads and events
  input wire logic [gpio_group_pkg::PINS-1:0] pad_in,
  input wire gpio_group_pkg::pad_ctrl_t pad_ctrl,
  input wire logic key_reset_req
);
  import gpio_group_pkg::*;
  // sync plus four filter periods
  localparam int LIM = 8 + 4 * DEB_DIV;
  int high_run;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_run <= 0;
    end else if (!pad_in[0]) begin
      high_run <= 0;
    end else if (high_run < LIM) begin
      high_run <= high_run + 1;
    end
  end
  sequence wr_both;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_take;
    s_arvalid && s_arready;
  endsequence
  drive_no_pull_a: assert property ((pad_ctrl.oe & (pad_ctrl.pull_up | pad_ctrl.pull_down)) == 8'h00)
    else $error("pull on driven pin");
  pull_one_way_a: assert property ((pad_ctrl.pull_up & pad_ctrl.pull_down) == 8'h00)
    else $error("both pulls on");
  write_answer_a: assert property (wr_both ##0 (s_awaddr <= OFS_GROUP_SUMMARY && s_awaddr[1:0] == 2'h0)
    |-> ##2 (s_bvalid && s_bresp == RESP_OKAY))
    else $error("bad write answer");
  read_answer_a: assert property (rd_take |=> s_rvalid)
    else $error("read data late");
  read_busy_a: assert property (s_rvalid |-> !s_arready)
    else $error("read overlap");
  unmapped_read_a: assert property (rd_take ##0 (s_araddr > OFS_GROUP_SUMMARY || s_araddr[1:0] != 2'h0)
    |=> (s_rresp == RESP_SLVERR && s_rdata == 32'h0000_0000))
    else $error("unmapped read");
  upper_zero_a: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0000)
    else $error("upper bits set");
  key_release_a: assert property (high_run == LIM |-> !key_reset_req)
    else $error("key reset pin 0 high");
endmodule : gpio_group_checks
`default_nettype wire

//--- bench/pin_board_model.sv
// board side of the pins: other drivers, pulls and floating pads
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  // clock
  input wire logic clk,
  // pads
  input wire gpio_group_pkg::pad_ctrl_t pad_ctrl,
  input wire logic [gpio_group_pkg::PINS-1:0] ext_val,
  input wire logic [gpio_group_pkg::PINS-1:0] ext_en,
  output logic [gpio_group_pkg::PINS-1:0] pad_in
);
  import gpio_group_pkg::*;
  logic [PINS-1:0] last = 8'h00;
  always @(posedge clk) last <= pad_in;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pad_ctrl.oe[i]) pad_in[i] = pad_ctrl.out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_ctrl.pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_ctrl.pull_down[i]) pad_in[i] = 1'b0;
      // floating pad shows the inverse
      else pad_in[i] = ~last[i];
    end
  end
endmodule : pin_board_model
`default_nettype wire

//--- bench/gpio_port_group_edge_irq_test.sv
// self-checking bench for the gpio port group
`timescale 1ns/1ps
`default_nettype none
module gpio_port_group_edge_irq_test;
  import gpio_group_pkg::*;
  localparam int DEB_DIV = 2;
  logic clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, key_reset_req;
  logic [ADDR_W-1:0] s_awaddr, s_araddr;
  logic [DATA_W-1:0] s_wdata, s_rdata, rv;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr;
  logic [PINS-1:0] pad_in, periph_in, ext_val, ext_en, o, v, p, g, m;
  pad_ctrl_t pad_ctrl;
  periph_drive_t periph_drive;
  int failures = 0;
  int cmp_count = 0;
  gpio_port_group_edge_irq #(.DEB_DIV(DEB_DIV)) dut (.clk(clk), .rst_n(rst_n),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .pad_in(pad_in), .pad_ctrl(pad_ctrl), .periph_drive(periph_drive),
    .periph_in(periph_in), .irq(irq), .key_reset_req(key_reset_req));
  pin_board_model board (.clk(clk), .pad_ctrl(pad_ctrl), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(pad_in));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1, w = 1;
    s_awvalid <= 1;
    s_awaddr <= a;
    s_wvalid <= 1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_awready) begin
        s_awvalid <= 0;
        aw = 0;
      end
      if (w && s_wready) begin
        s_wvalid <= 0;
        w = 0;
      end
    end
    s_bready <= 1;
    do @(posedge clk); while (!s_bvalid);
    s_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_arvalid <= 1;
    s_araddr <= a;
    do @(posedge clk); while (!s_arready);
    s_arvalid <= 0;
    s_rready <= 1;
    do @(posedge clk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 0;
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rr);
    chk(nm, rv, e);
  endtask : rchk
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {ext_val, ext_en, periph_drive} = '0;
    void'($urandom(43308));
    fork
      begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
      end
    join_none
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) rchk("reset value", 8'(4 * i), 32'h0);
    rd(8'h24, rv, rr);
    chk("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
    // pulls overridden by drive
    o = 8'($urandom);
    wr(OFS_PIN_PULL_CONTROL, 32'h0000_00FF);
    wr(OFS_PIN_DATA, {16'h0, o, 8'hA5});
    wr(OFS_PIN_IO_GATE, 32'h0000_FFFF);
    repeat (10) @(posedge clk);
    chk("pad out", 32'(pad_ctrl.out), 32'(o));
    chk("pad pulls", 32'(pad_ctrl.pull_up | pad_ctrl.pull_down), 32'h0);
    rchk("readback", OFS_PIN_DATA, {16'h0, o, o});
    p = 8'($urandom);
    g = 8'($urandom);
    wr(OFS_PIN_IO_GATE, 32'h0);
    wr(OFS_PIN_PULL_CONTROL, {16'h0, p, g});
    repeat (3) @(posedge clk);
    chk("pad oe", 32'(pad_ctrl.oe), 32'h0);
    chk("pull up", 32'(pad_ctrl.pull_up), 32'(p & g));
    chk("pull down", 32'(pad_ctrl.pull_down), 32'(~p & g));
    // input gating
    v = 8'($urandom);
    ext_en <= 8'hFF;
    ext_val <= v;
    wr(OFS_PIN_IO_GATE, 32'h0000_FF00);
    repeat (10) @(posedge clk);
    rchk("input", OFS_PIN_DATA, {16'h0, o, v});
    wr(OFS_PIN_IO_GATE, 32'h0);
    repeat (10) @(posedge clk);
    rchk("input off", OFS_PIN_DATA, {16'h0, o, 8'h00});
    // edge flags and summary
    ext_val <= 8'h00;
    wr(OFS_PIN_IO_GATE, 32'h0000_FF00);
    repeat (10) @(posedge clk);
    wr(OFS_EDGE_EVENT_FLAGS, 32'h0000_FFFF);
    rchk("flags clear", OFS_EDGE_EVENT_FLAGS, 32'h0);
    ext_val <= 8'h04;
    repeat (10) @(posedge clk);
    rchk("rise flag", OFS_EDGE_EVENT_FLAGS, 32'h0004);
    chk("irq masked", 32'(irq), 32'h0);
    rchk("summary masked", OFS_GROUP_SUMMARY, 32'h0);
    wr(OFS_EDGE_EVENT_ENABLES, 32'h0000_0004);
    repeat (4) @(posedge clk);
    chk("irq on", 32'(irq), 32'h1);
    rchk("summary on", OFS_GROUP_SUMMARY, 32'h1);
    wr(OFS_EDGE_EVENT_FLAGS, 32'h0);
    rchk("write zero", OFS_EDGE_EVENT_FLAGS, 32'h0004);
    wr(OFS_EDGE_EVENT_FLAGS, 32'h0000_0004);
    repeat (3) @(posedge clk);
    rchk("summary cleared", OFS_GROUP_SUMMARY, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    ext_val <= 8'h00;
    repeat (10) @(posedge clk);
    rchk("fall flag", OFS_EDGE_EVENT_FLAGS, 32'h0400);
    chk("fall masked", 32'(irq), 32'h0);
    wr(OFS_EDGE_EVENT_ENABLES, 32'h0000_0400);
    repeat (4) @(posedge clk);
    chk("fall irq", 32'(irq), 32'h1);
    wr(OFS_EDGE_EVENT_ENABLES, 32'h0);
    wr(OFS_EDGE_EVENT_FLAGS, 32'h0000_FFFF);
    // pin 3 to peripheral, gpio drive ignored
    periph_drive <= {8'($urandom), 8'h00};
    wr(OFS_PERIPHERAL_SELECT, 32'h0000_0008);
    wr(OFS_PIN_IO_GATE, 32'h0000_FF08);
    ext_val <= 8'h08;
    repeat (10) @(posedge clk);
    chk("periph oe", 32'(pad_ctrl.oe[3]), 32'h0);
    chk("periph out", 32'(pad_ctrl.out[3]), 32'(periph_drive.out[3]));
    chk("periph in", 32'(periph_in[3]), 32'h1);
    rd(OFS_PIN_DATA, rv, rr);
    chk("periph input bit", 32'(rv[3]), 32'h0);
    rchk("periph no flag", OFS_EDGE_EVENT_FLAGS, 32'h0);
    // unfiltered key reset
    ext_val <= 8'hFF;
    wr(OFS_PERIPHERAL_SELECT, 32'h0);
    wr(OFS_PIN_IO_GATE, 32'h0000_FF00);
    for (int c = 1; c < 4; c++) begin
      m = 8'((1 << (c + 1)) - 1);
      wr(OFS_KEY_RESET_SELECT, 32'(c));
      ext_val <= ~(m >> 1);
      repeat (10) @(posedge clk);
      chk("key partial", 32'(key_reset_req), 32'h0);
      ext_val <= ~m;
      repeat (10) @(posedge clk);
      chk("key all low", 32'(key_reset_req), 32'h1);
      ext_val <= 8'hFF;
      repeat (20) @(posedge clk);
    end
    wr(OFS_KEY_RESET_SELECT, 32'h0);
    ext_val <= 8'h00;
    repeat (10) @(posedge clk);
    chk("key off", 32'(key_reset_req), 32'h0);
    // filtered key reset
    ext_val <= 8'hFF;
    wr(OFS_DEBOUNCE_ENABLES, 32'h0000_FFFF);
    rchk("debounce reg", OFS_DEBOUNCE_ENABLES, 32'h0000_00FF);
    wr(OFS_KEY_RESET_SELECT, 32'h1);
    repeat (30) @(posedge clk);
    ext_val <= 8'hFC;
    rr = 0;
    for (int t = 0; t < 22; t++) begin
      @(posedge clk);
      if (t == 1) ext_val <= 8'hFF;
      rr[0] |= key_reset_req;
    end
    chk("glitch", 32'(rr), 32'h0);
    wr(OFS_EDGE_EVENT_FLAGS, 32'h0000_FFFF);
    ext_val <= 8'hFC;
    repeat (40) @(posedge clk);
    chk("key filtered", 32'(key_reset_req), 32'h1);
    rchk("key pins input", OFS_PIN_DATA, {16'h0, o, 8'hFC});
    rchk("key pins flags", OFS_EDGE_EVENT_FLAGS, 32'h0300);
    wrap_up();
  end
endmodule : gpio_port_group_edge_irq_test
bind gpio_port_group_edge_irq gpio_group_checks #(.DEB_DIV(DEB_DIV)) checks (.clk(clk),
  .rst_n(rst_n), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bresp(s_bresp),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid),
  .s_rdata(s_rdata), .s_rresp(s_rresp), .pad_in(pad_in), .pad_ctrl(pad_ctrl),
  .key_reset_req(key_reset_req));
`default_nettype wire
